//--- inc/tx_timer_pkg.sv
// constants, field layout and types shared by the transmitter keying timers
package tx_timer_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [11:0] A_CTRL = 12'h000; // timeout minutes, own channel
  localparam logic [11:0] A_HANG = 12'h004; // hang count, 32 ms units
  localparam logic [11:0] A_DROP = 12'h008; // drop count, 32 ms units
  localparam logic [11:0] A_FADE = 12'h00c; // carrier fade count, 32 ms units
  localparam logic [11:0] A_STAT = 12'h010; // live state, read only
  localparam logic [11:0] A_ISR = 12'h014; // sticky events, clear on read
  localparam logic [11:0] A_IMR = 12'h018; // interrupt mask
  localparam logic [11:0] A_PRES = 12'h01c; // channel present mask
  localparam logic [11:0] A_CHS = 12'h080; // 21 channel status words
  localparam logic [11:0] A_DIS = 12'h100; // 20 disable activate counts
  localparam logic [11:0] A_DCS = 12'h800; // 400 squelch code slots
  // ==========================================
  // table sizes and field positions
  localparam int NCH = 20;
  localparam int NSLOT = 21;
  localparam int NDCS = 400;
  localparam int DCS_PER_CH = 20;
  localparam int CTRL_TMO_LSB = 0;
  localparam int CTRL_CH_LSB = 8;
  localparam int CHS_ST_LSB = 16;
  localparam logic [4:0] VAL_SLOT = 5'h14; // slot 21, zero based
  // ==========================================
  // reset values and limits
  localparam logic [2:0] TMO_RST = 3'h0;
  localparam logic [2:0] TMO_MAX = 3'h6;
  localparam logic [7:0] HANG_RST = 8'h28;
  localparam logic [7:0] DROP_RST = 8'h28;
  localparam logic [7:0] FADE_RST = 8'h01;
  localparam logic [7:0] CNT_MIN = 8'h28;
  localparam logic [7:0] CNT_MAX = 8'hfe;
  localparam logic [7:0] DIS_RST = 8'h00;
  localparam logic [6:0] DCS_RST = 7'h00;
  localparam logic [6:0] DCS_MAX = 7'h68;
  localparam logic [2:0] IMR_RST = 3'h0;
  localparam logic [19:0] PRES_RST = 20'h00000;
  // ==========================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int T_FAST_MS = 32;
  localparam int T_SLOW_MS = 100;
  localparam int MIN_MS = 60000;
  localparam int FAST_CYC = T_FAST_MS * 1000 * CLK_MHZ;
  localparam int SLOW_CYC = T_SLOW_MS * 1000 * CLK_MHZ;
  localparam logic [11:0] SLOW_PER_MIN = 12'(MIN_MS / T_SLOW_MS);
  // ==========================================
  // interrupt bits
  localparam int IRQ_TOUT = 0;
  localparam int IRQ_DIS = 1;
  localparam int IRQ_INV = 2;
  // ==========================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACT = 3'b001,
    ST_HANG = 3'b010,
    ST_DROP = 3'b011,
    ST_TOUT = 3'b100
  } state_t;
  typedef enum logic [1:0] {
    CS_ABSENT = 2'b00,
    CS_IDLE = 2'b01,
    CS_USER = 2'b10
  } chan_st_t;
endpackage

//--- rtl/tx_key_timers.sv
// repeater transmitter keying timers with channel status and config tables
`timescale 1ns/100ps
module tx_key_timers #(
  parameter int FAST_CYCLES = tx_timer_pkg::FAST_CYC,
  parameter int SLOW_CYCLES = tx_timer_pkg::SLOW_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // radio pins, asynchronous
  input wire logic mob_det_pin,
  input wire logic carrier_pin,
  input wire logic code_valid_pin,
  // decoded key events from the data decoder
  input wire logic evt_stb,
  input wire logic evt_key,
  input wire logic evt_valid_id,
  input wire logic [4:0] evt_chan,
  input wire logic [15:0] evt_id,
  // transmitter control
  output logic tx_key,
  output logic tx_encode,
  output logic repeater_disable_detect,
  output logic shutdown_req,
  output logic [15:0] shutdown_id,
  // interrupt
  output logic irq
);
  // ==========================================
  // helpers
  // clamp a hang or drop entry into the legal window
  function automatic logic [7:0] clamp_cnt(input logic [7:0] v);
    if (v < tx_timer_pkg::CNT_MIN) begin
      return tx_timer_pkg::CNT_MIN;
    end else if (v > tx_timer_pkg::CNT_MAX) begin
      return tx_timer_pkg::CNT_MAX;
    end
    return v;
  endfunction
  // word address inside a table window
  function automatic logic in_win(input logic [11:0] a, input logic [11:0] base, input int n);
    return (a >= base) && ({20'h00000, a} < {20'h00000, base} + 32'(n * 4)) && (a[1:0] == 2'h0);
  endfunction
  // ==========================================
  // pin synchronisers
  logic [2:0] pin_s1_reg; // first stage, read only by second
  logic [2:0] pin_s2_reg; // usable levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {code_valid_pin, carrier_pin, mob_det_pin};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic mob;
  logic carrier;
  logic code_ok;
  assign mob = pin_s2_reg[0];
  assign carrier = pin_s2_reg[1];
  assign code_ok = pin_s2_reg[2];
  // ==========================================
  // tick strobes
  logic [31:0] fast_cnt_reg;
  logic [31:0] slow_cnt_reg;
  logic t32_reg; // one cycle every 32 ms
  logic t100_reg; // one cycle every 100 ms
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fast_cnt_reg <= 32'h0;
      slow_cnt_reg <= 32'h0;
      t32_reg <= 1'b0;
      t100_reg <= 1'b0;
    end else begin
      t32_reg <= (fast_cnt_reg == 32'(FAST_CYCLES - 1));
      t100_reg <= (slow_cnt_reg == 32'(SLOW_CYCLES - 1));
      fast_cnt_reg <= (fast_cnt_reg == 32'(FAST_CYCLES - 1)) ? 32'h0 : fast_cnt_reg + 32'h1;
      slow_cnt_reg <= (slow_cnt_reg == 32'(SLOW_CYCLES - 1)) ? 32'h0 : slow_cnt_reg + 32'h1;
    end
  end
  // ==========================================
  // configuration registers
  logic [2:0] tmo_reg; // timeout minutes
  logic [4:0] own_ch_reg; // this repeater's channel, zero based
  logic [7:0] hang_reg;
  logic [7:0] drop_reg;
  logic [7:0] fade_reg;
  logic [2:0] imr_reg;
  logic [19:0] pres_reg;
  logic [7:0] dis_mem [tx_timer_pkg::NCH];
  logic [6:0] dcs_mem [tx_timer_pkg::NDCS];
  logic acc; // access phase completing this edge
  logic wr;
  logic [8:0] dcs_idx;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign dcs_idx = 9'((paddr - tx_timer_pkg::A_DCS) >> 2);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tmo_reg <= tx_timer_pkg::TMO_RST;
      own_ch_reg <= 5'h00;
      hang_reg <= tx_timer_pkg::HANG_RST;
      drop_reg <= tx_timer_pkg::DROP_RST;
      fade_reg <= tx_timer_pkg::FADE_RST;
      imr_reg <= tx_timer_pkg::IMR_RST;
      pres_reg <= tx_timer_pkg::PRES_RST;
    end else if (wr) begin
      case (paddr)
        tx_timer_pkg::A_CTRL: begin
          // entries above six minutes saturate
          tmo_reg <= (pwdata[tx_timer_pkg::CTRL_TMO_LSB +: 3] > tx_timer_pkg::TMO_MAX) ?
                     tx_timer_pkg::TMO_MAX : pwdata[tx_timer_pkg::CTRL_TMO_LSB +: 3];
          own_ch_reg <= pwdata[tx_timer_pkg::CTRL_CH_LSB +: 5];
        end
        tx_timer_pkg::A_HANG: hang_reg <= clamp_cnt(pwdata[7:0]);
        // the wider hang window is used for drop too, not the lower table cap
        tx_timer_pkg::A_DROP: drop_reg <= clamp_cnt(pwdata[7:0]);
        tx_timer_pkg::A_FADE: fade_reg <= pwdata[7:0];
        tx_timer_pkg::A_IMR: imr_reg <= pwdata[2:0];
        tx_timer_pkg::A_PRES: pres_reg <= pwdata[19:0];
        default: ;
      endcase
    end
  end
  // per channel tables, reset to zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < tx_timer_pkg::NCH; i++) begin
        dis_mem[i] <= tx_timer_pkg::DIS_RST;
      end
      for (int i = 0; i < tx_timer_pkg::NDCS; i++) begin
        dcs_mem[i] <= tx_timer_pkg::DCS_RST;
      end
    end else if (wr) begin
      if (in_win(paddr, tx_timer_pkg::A_DIS, tx_timer_pkg::NCH)) begin
        // 255 is out of range and is held at 254
        dis_mem[paddr[6:2]] <= (pwdata[7:0] > tx_timer_pkg::CNT_MAX) ?
                               tx_timer_pkg::CNT_MAX : pwdata[7:0];
      end
      if (in_win(paddr, tx_timer_pkg::A_DCS, tx_timer_pkg::NDCS)) begin
        dcs_mem[dcs_idx] <= (pwdata[6:0] > tx_timer_pkg::DCS_MAX) ?
                            tx_timer_pkg::DCS_MAX : pwdata[6:0];
      end
    end
  end
  // ==========================================
  // repeater disable activate timer
  logic [7:0] dis_cnt_reg;
  logic [7:0] dis_lim;
  logic dis_hit;
  assign dis_lim = (own_ch_reg < 5'(tx_timer_pkg::NCH)) ? dis_mem[own_ch_reg] : 8'h00;
  assign dis_hit = (dis_lim != 8'h00) && (dis_cnt_reg >= dis_lim);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dis_cnt_reg <= 8'h00;
      repeater_disable_detect <= 1'b0;
    end else begin
      // carrier without a valid code runs the count; a valid code zeros it
      if (!carrier || code_ok) begin
        dis_cnt_reg <= 8'h00;
      end else if (t100_reg && dis_cnt_reg != 8'hff) begin
        dis_cnt_reg <= dis_cnt_reg + 8'h01;
      end
      repeater_disable_detect <= dis_hit;
    end
  end
  // ==========================================
  // carrier fade counter
  logic [7:0] fade_cnt_reg;
  logic fade_hit;
  assign fade_hit = (fade_reg != 8'h00) && (fade_cnt_reg >= fade_reg);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fade_cnt_reg <= 8'h00;
    end else if (carrier) begin
      fade_cnt_reg <= 8'h00;
    end else if (t32_reg && fade_cnt_reg != 8'hff) begin
      fade_cnt_reg <= fade_cnt_reg + 8'h01;
    end
  end
  // ==========================================
  // keying state machine
  tx_timer_pkg::state_t state_reg;
  tx_timer_pkg::state_t state_next;
  logic [11:0] tmo_cnt_reg; // 100 ms ticks while keyed
  logic [7:0] tmr_reg; // 32 ms ticks in hang or drop
  logic [11:0] tmo_lim;
  logic tmo_hit;
  assign tmo_lim = 12'(tmo_reg * tx_timer_pkg::SLOW_PER_MIN);
  assign tmo_hit = (tmo_reg != 3'h0) && t100_reg && (tmo_cnt_reg == tmo_lim - 12'h001);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tx_timer_pkg::ST_IDLE: begin
        // a disabled controller takes no new traffic
        if (mob && !repeater_disable_detect) begin
          state_next = tx_timer_pkg::ST_ACT;
        end
      end
      tx_timer_pkg::ST_ACT: begin
        if (!mob) begin
          state_next = tx_timer_pkg::ST_HANG;
        end else if (tmo_hit) begin
          state_next = tx_timer_pkg::ST_TOUT;
        end
      end
      tx_timer_pkg::ST_HANG: begin
        if (mob) begin
          state_next = tx_timer_pkg::ST_ACT;
        end else if (fade_hit) begin
          state_next = tx_timer_pkg::ST_IDLE;
        end else if (t32_reg && tmr_reg == hang_reg - 8'h01) begin
          state_next = tx_timer_pkg::ST_DROP;
        end
      end
      tx_timer_pkg::ST_DROP: begin
        if (mob) begin
          state_next = tx_timer_pkg::ST_ACT;
        end else if (fade_hit) begin
          state_next = tx_timer_pkg::ST_IDLE;
        end else if (t32_reg && tmr_reg == drop_reg - 8'h01) begin
          state_next = tx_timer_pkg::ST_IDLE;
        end
      end
      // held off until the mobile lets go, so a stuck mic cannot rekey
      tx_timer_pkg::ST_TOUT: begin
        if (!mob) begin
          state_next = tx_timer_pkg::ST_IDLE;
        end
      end
      default: state_next = tx_timer_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= tx_timer_pkg::ST_IDLE;
      tmo_cnt_reg <= 12'h000;
      tmr_reg <= 8'h00;
      tx_key <= 1'b0;
      tx_encode <= 1'b0;
    end else begin
      state_reg <= state_next;
      // the timeout count restarts on every fresh key
      if (state_next != tx_timer_pkg::ST_ACT || state_reg != tx_timer_pkg::ST_ACT) begin
        tmo_cnt_reg <= 12'h000;
      end else if (t100_reg) begin
        tmo_cnt_reg <= tmo_cnt_reg + 12'h001;
      end
      if (state_next != state_reg) begin
        tmr_reg <= 8'h00;
      end else if (t32_reg) begin
        tmr_reg <= tmr_reg + 8'h01;
      end
      tx_key <= (state_next == tx_timer_pkg::ST_ACT) || (state_next == tx_timer_pkg::ST_HANG) ||
                (state_next == tx_timer_pkg::ST_DROP);
      tx_encode <= (state_next == tx_timer_pkg::ST_ACT) || (state_next == tx_timer_pkg::ST_HANG);
    end
  end
  // ==========================================
  // channel status slots
  logic [20:0] chs_act_reg; // user present in slot
  logic [15:0] chs_id_reg [tx_timer_pkg::NSLOT];
  logic inv_evt;
  assign inv_evt = evt_stb && !evt_valid_id;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chs_act_reg <= 21'h000000;
      for (int i = 0; i < tx_timer_pkg::NSLOT; i++) begin
        chs_id_reg[i] <= 16'h0000;
      end
      shutdown_req <= 1'b0;
      shutdown_id <= 16'h0000;
    end else begin
      shutdown_req <= 1'b0;
      if (evt_stb && evt_valid_id && evt_chan < 5'(tx_timer_pkg::NCH)) begin
        chs_act_reg[evt_chan] <= evt_key;
        chs_id_reg[evt_chan] <= evt_id;
      end
      if (inv_evt) begin
        chs_act_reg[tx_timer_pkg::VAL_SLOT] <= 1'b1;
        chs_id_reg[tx_timer_pkg::VAL_SLOT] <= evt_id;
        if (evt_chan == own_ch_reg) begin
          shutdown_req <= 1'b1;
          shutdown_id <= evt_id;
        end
      end
    end
  end
  // status state of one slot
  function automatic tx_timer_pkg::chan_st_t slot_state(input logic [4:0] s);
    if (s != tx_timer_pkg::VAL_SLOT && !pres_reg[s]) begin
      return tx_timer_pkg::CS_ABSENT;
    end
    return chs_act_reg[s] ? tx_timer_pkg::CS_USER : tx_timer_pkg::CS_IDLE;
  endfunction
  // ==========================================
  // interrupts
  logic [2:0] isr_reg;
  logic [2:0] isr_ev;
  logic [2:0] isr_next;
  logic isr_rd;
  logic dis_prev_reg;
  assign isr_rd = acc && !pwrite && paddr == tx_timer_pkg::A_ISR;
  always_comb begin
    isr_ev = 3'h0;
    isr_ev[tx_timer_pkg::IRQ_TOUT] = (state_reg == tx_timer_pkg::ST_ACT) && (state_next == tx_timer_pkg::ST_TOUT);
    isr_ev[tx_timer_pkg::IRQ_DIS] = repeater_disable_detect && !dis_prev_reg;
    isr_ev[tx_timer_pkg::IRQ_INV] = inv_evt;
    // a new event on the clearing read still lands
    isr_next = (isr_rd ? 3'h0 : isr_reg) | isr_ev;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      isr_reg <= 3'h0;
      dis_prev_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      isr_reg <= isr_next;
      dis_prev_reg <= repeater_disable_detect;
      irq <= |(isr_next & imr_reg);
    end
  end
  // ==========================================
  // apb read path, one wait state
  logic [31:0] rd_mux;
  logic mapped;
  always_comb begin
    rd_mux = 32'h0;
    mapped = 1'b1;
    case (paddr)
      tx_timer_pkg::A_CTRL: rd_mux = {19'h0, own_ch_reg, 5'h0, tmo_reg};
      tx_timer_pkg::A_HANG: rd_mux = {24'h0, hang_reg};
      tx_timer_pkg::A_DROP: rd_mux = {24'h0, drop_reg};
      tx_timer_pkg::A_FADE: rd_mux = {24'h0, fade_reg};
      tx_timer_pkg::A_STAT: rd_mux = {26'h0, repeater_disable_detect, tx_encode, tx_key, state_reg};
      tx_timer_pkg::A_ISR: rd_mux = {29'h0, isr_reg};
      tx_timer_pkg::A_IMR: rd_mux = {29'h0, imr_reg};
      tx_timer_pkg::A_PRES: rd_mux = {12'h0, pres_reg};
      default: begin
        if (in_win(paddr, tx_timer_pkg::A_CHS, tx_timer_pkg::NSLOT)) begin
          rd_mux = {14'h0, slot_state(5'(paddr[6:2])), chs_id_reg[5'(paddr[6:2])]};
        end else if (in_win(paddr, tx_timer_pkg::A_DIS, tx_timer_pkg::NCH)) begin
          rd_mux = {24'h0, dis_mem[paddr[6:2]]};
        end else if (in_win(paddr, tx_timer_pkg::A_DCS, tx_timer_pkg::NDCS)) begin
          rd_mux = {25'h0, dcs_mem[dcs_idx]};
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        prdata <= (mapped && !pwrite) ? rd_mux : 32'h0;
      end
    end
  end
  // ==========================================
  // checks
  chk_tmo_zero: assert property (@(posedge clk) disable iff (!resetn)
    (tmo_reg == 3'h0 && state_reg == tx_timer_pkg::ST_ACT) |=> state_reg != tx_timer_pkg::ST_TOUT)
    else $error("timeout fired while disabled");
  chk_tout_count: assert property (@(posedge clk) disable iff (!resetn)
    $rose(state_reg == tx_timer_pkg::ST_TOUT) |-> $past(tmo_cnt_reg) == $past(tmo_lim) - 12'h001)
    else $error("timeout at wrong count");
  chk_tout_off: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == tx_timer_pkg::ST_TOUT |-> !tx_key && !tx_encode)
    else $error("transmitter up after timeout");
  chk_hang_enc: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == tx_timer_pkg::ST_HANG |-> tx_key && tx_encode)
    else $error("no encoding during hang");
  chk_hang_range: assert property (@(posedge clk) disable iff (!resetn)
    hang_reg >= tx_timer_pkg::CNT_MIN && hang_reg <= tx_timer_pkg::CNT_MAX)
    else $error("hang count out of range");
  chk_drop_keyed: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == tx_timer_pkg::ST_DROP |-> tx_key && !tx_encode)
    else $error("drop keying wrong");
  chk_drop_range: assert property (@(posedge clk) disable iff (!resetn)
    drop_reg >= tx_timer_pkg::CNT_MIN && drop_reg <= tx_timer_pkg::CNT_MAX)
    else $error("drop count out of range");
  chk_fade_force: assert property (@(posedge clk) disable iff (!resetn)
    (fade_hit && !mob && (state_reg == tx_timer_pkg::ST_HANG || state_reg == tx_timer_pkg::ST_DROP))
    |=> state_reg == tx_timer_pkg::ST_IDLE && !tx_key)
    else $error("fade did not drop transmitter");
  chk_slot_val: assert property (@(posedge clk) disable iff (!resetn)
    inv_evt |=> chs_act_reg[tx_timer_pkg::VAL_SLOT] && chs_id_reg[tx_timer_pkg::VAL_SLOT] == $past(evt_id))
    else $error("invalid id not in slot 21");
  chk_shut_id: assert property (@(posedge clk) disable iff (!resetn)
    (inv_evt && evt_chan == own_ch_reg) |=> shutdown_req && shutdown_id == $past(evt_id) ##1 !shutdown_req)
    else $error("shutdown code not sent");
  chk_tick_gap: assert property (@(posedge clk) disable iff (!resetn)
    t32_reg |=> !t32_reg)
    else $error("tick strobe longer than a cycle");
  cov_timeout: cover property (@(posedge clk) disable iff (!resetn) $rose(state_reg == tx_timer_pkg::ST_TOUT));
  cov_full_tail: cover property (@(posedge clk) disable iff (!resetn)
    state_reg == tx_timer_pkg::ST_DROP ##1 state_reg == tx_timer_pkg::ST_IDLE);
  cov_dis: cover property (@(posedge clk) disable iff (!resetn) $rose(repeater_disable_detect));
  cov_shut: cover property (@(posedge clk) disable iff (!resetn) shutdown_req);
endmodule

//--- tb/radio_model.sv
// radio model driving the receive detect pins of the keying timers
`timescale 1ns/100ps
module radio_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pin states the bench asks for
  input wire logic want_key,
  input wire logic want_car,
  input wire logic want_code,
  // receive detect pins
  output logic mob_det_pin,
  output logic carrier_pin,
  output logic code_valid_pin
);
  // ==========================================
  // pins lag one edge behind the request, like a slow receiver
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mob_det_pin <= 1'b0;
      carrier_pin <= 1'b0;
      code_valid_pin <= 1'b0;
    end else begin
      mob_det_pin <= want_key;
      carrier_pin <= want_car;
      code_valid_pin <= want_code;
    end
  end
endmodule

//--- tb/repeater_tx_key_timers_tb.sv
// self-checking bench for the transmitter keying timers
`timescale 1ns/100ps
module repeater_tx_key_timers_tb;
  // ==========================================
  // bench signals
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, mob, car, cv, wk = 0, wc = 0, wv = 0;
  logic evt_stb = 0, evt_key = 0, evt_valid_id = 0;
  logic [4:0] evt_chan = 5'h00;
  logic [15:0] evt_id = 16'h0000, shutdown_id;
  logic tx_key, tx_encode, dis_det, shutdown_req, irq;
  int fails = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  // short tick periods keep the run small
  tx_key_timers #(.FAST_CYCLES(8), .SLOW_CYCLES(25)) u_tx_key_timers (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mob_det_pin(mob), .carrier_pin(car), .code_valid_pin(cv),
    .evt_stb(evt_stb), .evt_key(evt_key), .evt_valid_id(evt_valid_id), .evt_chan(evt_chan),
    .evt_id(evt_id), .tx_key(tx_key), .tx_encode(tx_encode), .repeater_disable_detect(dis_det),
    .shutdown_req(shutdown_req), .shutdown_id(shutdown_id), .irq(irq));
  radio_model u_radio_model (.clk(clk), .resetn(resetn), .want_key(wk), .want_car(wc),
    .want_code(wv), .mob_det_pin(mob), .carrier_pin(car), .code_valid_pin(cv));
  // ==========================================
  // compare helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic kk(input logic [1:0] x);
    chk({30'h0, tx_key, tx_encode}, {30'h0, x});
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a slave that never answers ends the run as a failure
    if (n >= 20) begin
      fails++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pins(input logic k, input logic c, input logic v);
    @(posedge clk);
    wk <= k;
    wc <= c;
    wv <= v;
  endtask
  task automatic evt(input logic k, input logic v, input logic [4:0] c, input logic [15:0] id);
    @(posedge clk);
    evt_stb <= 1;
    evt_key <= k;
    evt_valid_id <= v;
    evt_chan <= c;
    evt_id <= id;
    @(posedge clk);
    evt_stb <= 0;
    #1;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    rdc(tx_timer_pkg::A_CTRL, 32'h0);
    rdc(tx_timer_pkg::A_FADE, 32'h1);
    apb(1, tx_timer_pkg::A_HANG, 32'h5);
    rdc(tx_timer_pkg::A_HANG, 32'h28);
    apb(1, tx_timer_pkg::A_DROP, 32'hff);
    rdc(tx_timer_pkg::A_DROP, 32'hfe);
    apb(1, tx_timer_pkg::A_DIS + 12'h00c, 32'hff);
    rdc(tx_timer_pkg::A_DIS + 12'h00c, 32'hfe);
    apb(1, tx_timer_pkg::A_DCS + 12'h04c, 32'h7f);
    rdc(tx_timer_pkg::A_DCS + 12'h04c, 32'h68);
    rdc(tx_timer_pkg::A_DCS + 12'h050, 32'h0);
    apb(1, tx_timer_pkg::A_CTRL, 32'h7);
    rdc(tx_timer_pkg::A_CTRL, 32'h6);
    apb(0, 12'hffc, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_hang;
    apb(1, tx_timer_pkg::A_CTRL, 32'h300);
    apb(1, tx_timer_pkg::A_FADE, 32'h0);
    apb(1, tx_timer_pkg::A_DROP, 32'h28);
    pins(1, 1, 1);
    cyc(10);
    kk(2'b11);
    pins(0, 1, 1);
    cyc(300);
    kk(2'b11);
    cyc(40);
    kk(2'b10);
    cyc(270);
    kk(2'b10);
    cyc(70);
    kk(2'b00);
    $display("test hang done");
  endtask
  task automatic t_fade;
    apb(1, tx_timer_pkg::A_FADE, 32'h1);
    pins(1, 1, 1);
    cyc(10);
    pins(0, 0, 1);
    cyc(30);
    kk(2'b00);
    $display("test fade done");
  endtask
  task automatic t_tout;
    apb(1, tx_timer_pkg::A_IMR, 32'h1);
    apb(1, tx_timer_pkg::A_CTRL, 32'h301);
    pins(1, 1, 1);
    cyc(14800);
    kk(2'b11);
    cyc(400);
    kk(2'b00);
    chk({31'h0, irq}, 32'h1);
    rdc(tx_timer_pkg::A_STAT, 32'h4);
    rdc(tx_timer_pkg::A_ISR, 32'h1);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    pins(0, 1, 1);
    apb(1, tx_timer_pkg::A_CTRL, 32'h300);
    pins(1, 1, 1);
    cyc(15400);
    kk(2'b11);
    pins(0, 0, 1);
    cyc(40);
    $display("test timeout done");
  endtask
  task automatic t_evt;
    apb(1, tx_timer_pkg::A_PRES, 32'h8);
    apb(1, tx_timer_pkg::A_IMR, 32'h4);
    evt(1, 1, 5'h03, 16'h1234);
    rdc(tx_timer_pkg::A_CHS + 12'h00c, 32'h21234);
    evt(0, 1, 5'h03, 16'h1234);
    rdc(tx_timer_pkg::A_CHS + 12'h00c, 32'h11234);
    rdc(tx_timer_pkg::A_CHS + 12'h010, 32'h0);
    evt(1, 0, 5'h05, 16'h1111);
    chk({31'h0, shutdown_req}, 32'h0);
    evt(1, 0, 5'h03, 16'hbeef);
    chk({15'h0, shutdown_req, shutdown_id}, 32'h1beef);
    rdc(tx_timer_pkg::A_CHS + 12'h050, 32'h2beef);
    chk({31'h0, irq}, 32'h1);
    rdc(tx_timer_pkg::A_ISR, 32'h4);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    $display("test events done");
  endtask
  task automatic t_dis;
    apb(1, tx_timer_pkg::A_DIS + 12'h00c, 32'h2);
    apb(1, tx_timer_pkg::A_IMR, 32'h2);
    pins(0, 1, 0);
    cyc(80);
    chk({30'h0, dis_det, irq}, 32'h3);
    pins(1, 1, 0);
    cyc(10);
    kk(2'b00);
    pins(0, 1, 1);
    cyc(10);
    chk({31'h0, dis_det}, 32'h0);
    $display("test disable done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    cyc(2);
    resetn <= 1;
    t_regs();
    t_hang();
    t_fade();
    t_tout();
    t_evt();
    t_dis();
    end_sim();
  end
  initial begin
    #400000;
    fails++;
    end_sim();
  end
endmodule
